// file: pcg_regs.vh
// register offsets, field positions and reset values of the peripheral clock gate bank
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define PCG_GATE_SIX_OFFSET      16'h103C
`define PCG_GATE_SEVEN_OFFSET    16'h1040
`define PCG_LP_STATUS_OFFSET     16'h1048

// ****************************************
// field positions, group six
// ****************************************
`define PCG_DAC_BIT              31
`define PCG_RTC_BIT              29
`define PCG_ADC_BIT              27
`define PCG_TPM_C_BIT            26
`define PCG_TPM_B_BIT            25
`define PCG_TPM_A_BIT            24
`define PCG_PIT_BIT              23
`define PCG_DMA_REQUEST_MUX_GATE_BIT           1
`define PCG_FLASH_BIT            0

// ****************************************
// field positions, group seven
// ****************************************
`define PCG_DMA_BIT              8

// ****************************************
// writable masks and reset values
// ****************************************
`define PCG_SIX_MASK             32'hAF800003
`define PCG_SEVEN_MASK           32'h00000100
`define PCG_SIX_RESET            32'h00000001
`define PCG_SEVEN_RESET          32'h00000100

`endif

// file: pcg_clock_gate.v
// one glitch-free clock gate: enable taken on the falling edge, held through the high phase
// assumes enable is produced from flops on the rising edge of the same clock
`timescale 1ns/1ns
`default_nettype none

module pcg_clock_gate (
    input  wire clk_in,     // free-running clock
    input  wire enable,     // gate enable, high passes the clock
    output wire clk_out     // gated clock
);

    reg en_latch;

    // falling-edge flop: the enable only moves while the clock is low,
    // so a pulse already started is never cut short
    always @(negedge clk_in) begin
        en_latch <= enable;
    end

    assign clk_out = clk_in & en_latch;

endmodule // pcg_clock_gate

`default_nettype wire

// file: pcg_gate_bank.v
// peripheral clock gate bank: two gating registers on a classic wishbone slave
// assumes one system clock, synchronous reset and byte-addressed 32-bit words
//
// Function
// - bit 31 of group six enables the converter-output clock.
// - bit 29 of group six enables access and interrupts of the calendar clock.
// - bit 27 of group six enables the sampling converter clock.
// - bit 26 of group six enables the third timer clock.
// - bit 25 of group six enables the second timer clock.
// - bit 24 of group six enables the first timer clock.
// - bit 23 of group six enables the periodic timer clock.
// - bit 1 of group six enables the dma request mux clock.
// - bit 0 gates flash clock; flash reads stay served while gated.
// - flash gate closed refuses low-power entry until it is set again.
// - reserved bits of both registers read zero and ignore writes.
// - bit 8 of group seven enables the dma clock, set at reset.
//
// The Wishbone interface to the registers was chosen for this implementation.
`include "pcg_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module pcg_gate_bank #(
    parameter ADDR_W = 16           // decoded address width
) (
    input  wire              CLK,           // system bus clock, 100 MHz
    input  wire              RST,           // synchronous reset, active high
    input  wire              WB_CYC_I,      // wishbone cycle
    input  wire              WB_STB_I,      // wishbone strobe
    input  wire              WB_WE_I,       // wishbone write enable
    input  wire [ADDR_W-1:0] WB_ADR_I,      // wishbone byte address
    input  wire [3:0]        WB_SEL_I,      // wishbone byte selects
    input  wire [31:0]       WB_DAT_I,      // wishbone write data
    output reg  [31:0]       WB_DAT_O,      // wishbone read data
    output reg               WB_ACK_O,      // wishbone acknowledge
    output wire              WB_ERR_O,      // wishbone error, unmapped address
    input  wire              LP_REQ,        // low-power entry request
    output wire              LP_ALLOW,      // low-power entry allowed
    output wire              FLASH_RD_EN,   // flash read path enable
    output wire              RTC_ACCESS_EN, // calendar clock access enable
    output wire              RTC_IRQ_EN,    // calendar clock interrupt enable
    output wire              DAC_CLK,       // gated converter-output clock
    output wire              ADC_CLK,       // gated sampling converter clock
    output wire              TPM_C_CLK,     // gated third timer clock
    output wire              TPM_B_CLK,     // gated second timer clock
    output wire              TPM_A_CLK,     // gated first timer clock
    output wire              PIT_CLK,       // gated periodic timer clock
    output wire              DMA_REQUEST_MUX_GATE_CLK,    // gated dma request mux clock
    output wire              FLASH_CLK,     // gated flash clock
    output wire              DMA_CLK        // gated dma controller clock
);

    // ****************************************
    // registers
    // ****************************************
    reg  [31:0] gate_six_reg;
    reg  [31:0] gate_six_next;
    reg  [31:0] gate_seven_reg;
    reg  [31:0] gate_seven_next;
    reg         lp_refused_reg;
    reg         lp_refused_next;
    reg         ack_next;
    reg         err_reg;
    reg         err_next;
    reg  [31:0] rdata_next;

    wire        req;
    wire        hit_six;
    wire        hit_seven;
    wire        hit_lp;
    wire        hit_any;
    wire [31:0] sel_mask;

    // ****************************************
    // helpers
    // ****************************************
    // byte selects widened to a bit mask
    function [31:0] sel_to_mask;
        input [3:0] sel;
        begin
            sel_to_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        end
    endfunction

    // merge write data into a register through selects and writable mask
    function [31:0] merge_write;
        input [31:0] old_val;
        input [31:0] wdata;
        input [31:0] bmask;
        input [31:0] wmask;
        reg   [31:0] m;
        begin
            m = bmask & wmask;
            merge_write = (old_val & ~m) | (wdata & m);
        end
    endfunction

    // ****************************************
    // bus decode
    // ****************************************
    // a new request is one not yet answered; ack drops the cycle after
    assign req       = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~err_reg;
    assign hit_six   = (WB_ADR_I == `PCG_GATE_SIX_OFFSET);
    assign hit_seven = (WB_ADR_I == `PCG_GATE_SEVEN_OFFSET);
    assign hit_lp    = (WB_ADR_I == `PCG_LP_STATUS_OFFSET);
    assign hit_any   = hit_six | hit_seven | hit_lp;
    assign sel_mask  = sel_to_mask(WB_SEL_I);
    assign WB_ERR_O  = err_reg;

    // next register values and answers
    always @* begin
        gate_six_next   = gate_six_reg;
        gate_seven_next = gate_seven_reg;
        lp_refused_next = lp_refused_reg;
        ack_next        = 1'b0;
        err_next        = 1'b0;
        rdata_next      = WB_DAT_O;
        if (LP_REQ && !gate_six_reg[`PCG_FLASH_BIT]) begin
            lp_refused_next = 1'b1;
        end
        if (req) begin
            if (!hit_any) begin
                err_next = 1'b1;
            end else begin
                ack_next = 1'b1;
            end
            if (WB_WE_I) begin
                if (hit_six) begin
                    gate_six_next = merge_write(gate_six_reg, WB_DAT_I, sel_mask,
                                                `PCG_SIX_MASK);
                end else if (hit_seven) begin
                    gate_seven_next = merge_write(gate_seven_reg, WB_DAT_I, sel_mask,
                                                  `PCG_SEVEN_MASK);
                end else if (hit_lp) begin
                    // write one to bit 0 clears the refusal flag, a new refusal wins
                    if (WB_SEL_I[0] && WB_DAT_I[0] && !(LP_REQ
                            && !gate_six_reg[`PCG_FLASH_BIT])) begin
                        lp_refused_next = 1'b0;
                    end
                end
            end else begin
                if (hit_six) begin
                    rdata_next = gate_six_reg & `PCG_SIX_MASK;
                end else if (hit_seven) begin
                    rdata_next = gate_seven_reg & `PCG_SEVEN_MASK;
                end else if (hit_lp) begin
                    rdata_next = {30'h00000000, ~gate_six_reg[`PCG_FLASH_BIT],
                                  lp_refused_reg};
                end else begin
                    rdata_next = 32'h00000000;
                end
            end
        end
    end

    // register update
    always @(posedge CLK) begin
        if (RST) begin
            gate_six_reg   <= `PCG_SIX_RESET;
            gate_seven_reg <= `PCG_SEVEN_RESET;
            lp_refused_reg <= 1'b0;
            WB_ACK_O       <= 1'b0;
            err_reg        <= 1'b0;
            WB_DAT_O       <= 32'h00000000;
        end else begin
            gate_six_reg   <= gate_six_next;
            gate_seven_reg <= gate_seven_next;
            lp_refused_reg <= lp_refused_next;
            WB_ACK_O       <= ack_next;
            err_reg        <= err_next;
            WB_DAT_O       <= rdata_next;
        end
    end

    // ****************************************
    // enables to the peripherals
    // ****************************************
    // low power blocked
    assign LP_ALLOW      = gate_six_reg[`PCG_FLASH_BIT];
    assign FLASH_RD_EN   = 1'b1;
    assign RTC_ACCESS_EN = gate_six_reg[`PCG_RTC_BIT];
    assign RTC_IRQ_EN    = gate_six_reg[`PCG_RTC_BIT];

    // ****************************************
    // glitch-free clock gates
    // ****************************************
    // converter-output gate
    pcg_clock_gate u_dac (
        .clk_in  (CLK),
        .enable  (gate_six_reg[`PCG_DAC_BIT]),
        .clk_out (DAC_CLK)
    );

    pcg_clock_gate u_adc (
        .clk_in  (CLK),
        .enable  (gate_six_reg[`PCG_ADC_BIT]),
        .clk_out (ADC_CLK)
    );

    pcg_clock_gate u_tpm_c (
        .clk_in  (CLK),
        .enable  (gate_six_reg[`PCG_TPM_C_BIT]),
        .clk_out (TPM_C_CLK)
    );

    pcg_clock_gate u_tpm_b (
        .clk_in  (CLK),
        .enable  (gate_six_reg[`PCG_TPM_B_BIT]),
        .clk_out (TPM_B_CLK)
    );

    pcg_clock_gate u_tpm_a (
        .clk_in  (CLK),
        .enable  (gate_six_reg[`PCG_TPM_A_BIT]),
        .clk_out (TPM_A_CLK)
    );

    pcg_clock_gate u_pit (
        .clk_in  (CLK),
        .enable  (gate_six_reg[`PCG_PIT_BIT]),
        .clk_out (PIT_CLK)
    );

    pcg_clock_gate u_dma_request_mux_gate (
        .clk_in  (CLK),
        .enable  (gate_six_reg[`PCG_DMA_REQUEST_MUX_GATE_BIT]),
        .clk_out (DMA_REQUEST_MUX_GATE_CLK)
    );

    pcg_clock_gate u_flash (
        .clk_in  (CLK),
        .enable  (gate_six_reg[`PCG_FLASH_BIT]),
        .clk_out (FLASH_CLK)
    );

    pcg_clock_gate u_dma (
        .clk_in  (CLK),
        .enable  (gate_seven_reg[`PCG_DMA_BIT]),
        .clk_out (DMA_CLK)
    );

endmodule // pcg_gate_bank

`default_nettype wire

// file: pcg_gate_bank_assertions.sv
// checker for the gate bank bus answers, register fields and the gated flash clock
// bound into pcg_gate_bank, sees its ports only
`include "pcg_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module pcg_gate_bank_assertions #(
    parameter ADDR_W = 16               // address width
) (
    input wire logic              CLK,           // clock
    input wire logic              RST,           // sync reset
    input wire logic              WB_CYC_I,      // cycle
    input wire logic              WB_STB_I,      // strobe
    input wire logic              WB_WE_I,       // write
    input wire logic [ADDR_W-1:0] WB_ADR_I,      // address
    input wire logic [3:0]        WB_SEL_I,      // byte lanes
    input wire logic [31:0]       WB_DAT_I,      // write data
    input wire logic [31:0]       WB_DAT_O,      // read data
    input wire logic              WB_ACK_O,      // ack
    input wire logic              WB_ERR_O,      // error
    input wire logic              LP_ALLOW,      // low power allowed
    input wire logic              FLASH_RD_EN,   // flash reads
    input wire logic              RTC_ACCESS_EN, // calendar access
    input wire logic              RTC_IRQ_EN,    // calendar irq
    input wire logic              DAC_CLK,       // gated clock
    input wire logic              FLASH_CLK      // gated clock
);
    // ****
    // request sequences
    // ****
    wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
    wire mapped = WB_ADR_I == `PCG_GATE_SIX_OFFSET || WB_ADR_I == `PCG_GATE_SEVEN_OFFSET
                  || WB_ADR_I == `PCG_LP_STATUS_OFFSET;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence rd_at(a);
        take && !WB_WE_I && WB_ADR_I == a;
    endsequence
    sequence wr_six(b);
        take && WB_WE_I && WB_ADR_I == `PCG_GATE_SIX_OFFSET && WB_SEL_I[b];
    endsequence
    // one answer exactly one cycle after a taken request
    a_answer_next: assert property (take |=> WB_ACK_O != WB_ERR_O)
        else $error("request not answered once in the next cycle");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_rsvd_six: assert property (rd_at(`PCG_GATE_SIX_OFFSET) |=>
        (WB_DAT_O & ~`PCG_SIX_MASK) == 32'h0) else $error("group six reserved bit set");
    a_rsvd_seven: assert property (rd_at(`PCG_GATE_SEVEN_OFFSET) |=>
        (WB_DAT_O & ~32'h00000100) == 32'h0) else $error("group seven reserved bit set");
    a_unmapped_err: assert property (take && !mapped |=> WB_ERR_O && !WB_ACK_O)
        else $error("unmapped address not refused");
    a_lp_follow: assert property (wr_six(0) |=> LP_ALLOW == $past(WB_DAT_I[0]))
        else $error("low power permission differs from flash gate");
    a_rtc_follow: assert property (wr_six(3) |=> RTC_ACCESS_EN == $past(WB_DAT_I[29])
        && RTC_IRQ_EN == RTC_ACCESS_EN) else $error("calendar enables wrong");
    a_flash_reads: assert property (FLASH_RD_EN)
        else $error("flash reads blocked");
    a_gate_low: assert property (@(negedge CLK) FLASH_CLK == $past(LP_ALLOW))
        else $error("flash clock pulse does not follow its gate bit");
endmodule // pcg_gate_bank_assertions
bind pcg_gate_bank pcg_gate_bank_assertions #(.ADDR_W(ADDR_W)) i_pcg_gate_bank_assertions (
    .CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .LP_ALLOW(LP_ALLOW), .FLASH_RD_EN(FLASH_RD_EN),
    .RTC_ACCESS_EN(RTC_ACCESS_EN), .RTC_IRQ_EN(RTC_IRQ_EN), .DAC_CLK(DAC_CLK),
    .FLASH_CLK(FLASH_CLK));
`default_nettype wire

// file: pcg_periph_model.sv
// peripherals behind the gated clocks: each notes that its clock ticked
// clr is raised by the bench between checks
`timescale 1ns/1ns
`default_nettype none
module pcg_periph_model (
    input  wire logic       clr,  // clear all flags
    input  wire logic [8:0] gclk, // gated clocks
    output var  logic [8:0] seen  // an edge arrived since clear
);
    genvar i;
    // one edge witness per peripheral
    for (i = 0; i < 9; i++) begin : g_p
        always @(posedge gclk[i] or posedge clr) begin
            if (clr)
                seen[i] <= 1'b0;
            else
                seen[i] <= 1'b1;
        end
    end
endmodule // pcg_periph_model
`default_nettype wire

// file: pcg_gate_bank_tb.sv
// self-checking bench for the gate bank
// drives classic wishbone, watches gated clocks through the peripheral model
`include "pcg_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module pcg_gate_bank_tb;
    logic        clk, rst, cyc, stb, we, lp_req, clr, e;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, q, six;
    wire  [31:0] rdat;
    wire         ack, err, lp_allow, rd_en, rtc_a, rtc_i;
    wire  [8:0]  gclk, seen;
    int          err_total = 0, checks_done = 0;
    typedef struct {logic [15:0] a; logic [3:0] s; logic [31:0] d, x; logic [8:0] r;} pcg_row_t;
    // address, lanes, write data, read back, running clocks
    pcg_row_t rows [7] = '{'{16'h103C, 4'hF, 32'hFFFFFFFF, 32'hAF800003, 9'h1FF},
        '{16'h103C, 4'hF, 32'h0, 32'h0, 9'h001}, '{16'h103C, 4'h8, '1, 32'hAF000000, 9'h1F1},
        '{16'h103C, 4'h4, '1, 32'hAF800000, 9'h1F9}, '{16'h103C, 4'h1, 32'h2, 32'hAF800002, 9'h1FD},
        '{16'h1040, 4'hF, '1, 32'h100, 9'h1FD}, '{16'h1040, 4'h2, 32'h0, 32'h0, 9'h1FC}};
    pcg_gate_bank i_pcg_gate_bank (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .WB_ERR_O(err), .LP_REQ(lp_req), .LP_ALLOW(lp_allow),
        .FLASH_RD_EN(rd_en), .RTC_ACCESS_EN(rtc_a), .RTC_IRQ_EN(rtc_i), .DAC_CLK(gclk[8]),
        .ADC_CLK(gclk[7]), .TPM_C_CLK(gclk[6]), .TPM_B_CLK(gclk[5]), .TPM_A_CLK(gclk[4]),
        .PIT_CLK(gclk[3]), .DMA_REQUEST_MUX_GATE_CLK(gclk[2]), .FLASH_CLK(gclk[1]), .DMA_CLK(gclk[0]));
    pcg_periph_model i_pcg_periph_model (.clr(clr), .gclk(gclk), .seen(seen));
    // ****
    // tasks
    // ****
    task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            $display("wrong value %s expected %h seen %h", n, x, g);
            err_total++;
        end
    endtask
    // one classic cycle, held until ack or error
    task automatic wb(input logic [15:0] a, input logic w, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1 && ++n < 20);
        q = rdat;
        e = err;
        if (n >= 20) begin
            err_total++;
            wrap_up;
        end
        {cyc, stb} <= 2'b00;
    endtask
    // clear the witnesses, let three edges pass, compare
    task automatic clocks(input logic [8:0] x);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (3) @(posedge clk);
        cmp("gated clocks", {23'h0, x}, {23'h0, seen});
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        wrap_up;
    end
    // ****
    // main sequence
    // ****
    initial begin
        {cyc, stb, we, lp_req, clr, adr, sel, wdat} = '0;
        rst = 1'b1;
        six = 32'h1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb(16'h103C, 1'b0, 4'hF, 32'h0);
        cmp("six reset", 32'h1, q);
        wb(16'h1040, 1'b0, 4'hF, 32'h0);
        cmp("seven reset", 32'h100, q);
        clocks(9'h003);
        foreach (rows[i]) begin
            wb(rows[i].a, 1'b1, rows[i].s, rows[i].d);
            wb(rows[i].a, 1'b0, 4'hF, 32'h0);
            cmp("register", rows[i].x, q);
            if (rows[i].a == 16'h103C) six = rows[i].x;
            cmp("lp allow", {31'h0, six[0]}, {31'h0, lp_allow});
            cmp("rtc enables", {30'h0, {2{six[29]}}}, {30'h0, rtc_a, rtc_i});
            clocks(rows[i].r);
        end
        // unmapped write is refused and changes nothing
        wb(16'h1044, 1'b1, 4'hF, 32'hFFFFFFFF);
        cmp("unmapped error", 32'h1, {31'h0, e});
        wb(16'h103C, 1'b0, 4'hF, 32'h0);
        cmp("unmapped no change", 32'hAF800002, q);
        // low-power request while the flash gate is closed
        lp_req <= 1'b1;
        wb(16'h1048, 1'b0, 4'hF, 32'h0);
        cmp("refusal", 32'h3, q);
        lp_req <= 1'b0;
        wb(16'h1048, 1'b1, 4'hF, 32'h1);
        wb(16'h103C, 1'b1, 4'h1, 32'h1);
        lp_req <= 1'b1;
        wb(16'h1048, 1'b0, 4'hF, 32'h0);
        cmp("no refusal", 32'h0, q);
        cmp("lp allow open", 32'h1, {31'h0, lp_allow});
        // reset again in mid-run: registers go back to their reset values
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb(16'h103C, 1'b0, 4'hF, 32'h0);
        cmp("six after reset", 32'h1, q);
        wb(16'h1040, 1'b0, 4'hF, 32'h0);
        cmp("seven after reset", 32'h100, q);
        wb(16'h1048, 1'b0, 4'hF, 32'h0);
        cmp("flag after reset", 32'h0, q);
        wrap_up;
    end
endmodule // pcg_gate_bank_tb
`default_nettype wire
